/* File: logic/ovf_pkg.sv */
// Shared constants for the output voltage fault responder.
package ovf_pkg;

  // Clock rate and the supervisor sample period.
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned SAMPLE_PERIOD_NS = 12200;
  localparam logic [11:0] SAMPLE_CYCLES = 12'(SAMPLE_PERIOD_NS * 1000 / CLK_PERIOD_PS);

  // Turn-off delay step, limit and rounding boundary, counted in 10 us steps.
  localparam int unsigned TOFF_STEP_NS = 10000;
  localparam logic [11:0] TOFF_STEP_CYCLES = 12'(TOFF_STEP_NS * 1000 / CLK_PERIOD_PS);
  localparam logic [20:0] TOFF_MAX_STEPS = 21'h13_fd30;
  localparam logic [20:0] TOFF_COARSE_FROM = 21'h00_ffdc;
  localparam logic [20:0] TOFF_COARSE_STEP = 21'h00_0014;
  localparam logic [20:0] TOFF_COARSE_HALF = 21'h00_000a;

  // Field positions inside each fault policy byte.
  localparam int unsigned ACTION_LSB = 6;
  localparam int unsigned RETRY_LSB = 3;
  localparam int unsigned DEGLITCH_LSB = 0;

  // Action field encodings.
  localparam logic [1:0] ACT_CONTINUE = 2'h0;
  localparam logic [1:0] ACT_DELAYED = 2'h1;

  // Policy value after reset: keep running, no retry, no deglitch.
  localparam logic [7:0] POLICY_RESET = 8'h00;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] DEGLITCH_NONE = 3'h0;

  // Channel states, one-hot.
  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_ON = 4'h2,
    ST_SEQ_OFF = 4'h4,
    ST_FAULTED = 4'h8
  } ovf_state_e;

endpackage

/* File: logic/ovf_deglitch.sv */
// Deglitch counter for one supervisor fault comparator.
`timescale 1ns/100ps
module ovf_deglitch (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic sample_tick,
  input wire logic fault_raw,
  input wire logic [2:0] glitch_count,
  output logic confirmed
);

  typedef struct packed {
    logic [2:0] cnt;
    logic conf;
  } ovf_dg_s;

  ovf_dg_s q;
  ovf_dg_s next_q;

  // Count supervisor samples while the fault stands; any gap starts over.
  always_comb begin
    next_q = q;
    if (!fault_raw) begin
      next_q.cnt = 3'h0;
      next_q.conf = 1'b0;
    end else if (glitch_count == ovf_pkg::DEGLITCH_NONE) begin
      next_q.conf = 1'b1;
    end else if (sample_tick && !q.conf) begin
      next_q.cnt = q.cnt + 3'h1;
      next_q.conf = ((q.cnt + 3'h1) >= glitch_count);
    end
  end

  // State register.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign confirmed = q.conf;

  property p_dg_zero;
    @(posedge sys_clk) disable iff (reset)
      (fault_raw && glitch_count == 3'h0) |=> confirmed;
  endproperty
  a_dg_zero: assert property (p_dg_zero) else $error("zero deglitch did not confirm at once");

  property p_dg_gap;
    @(posedge sys_clk) disable iff (reset)
      !fault_raw |=> !confirmed;
  endproperty
  a_dg_gap: assert property (p_dg_gap) else $error("confirmation survived a fault gap");

  property p_dg_first;
    @(posedge sys_clk) disable iff (reset)
      ($rose(fault_raw) && glitch_count > 3'h1 && $stable(glitch_count)) |=> !confirmed;
  endproperty
  a_dg_first: assert property (p_dg_first) else $error("fault confirmed before its sample count");

endmodule

/* File: logic/ovf_responder.sv */
// Per-channel output overvoltage and undervoltage fault responder.
`timescale 1ns/100ps
// Contract
// - fault sets summary status byte and word bits (an undervoltage fault sets only the word bit in the code)
// - fault sets channel voltage status bit
// - fault drives alert line low
// - current-measuring channel ignores voltage faults entirely
// - action zero keeps channel running
// - delayed action shuts down if fault persists
// - upper action bit: immediate or sequenced off (the code ignores that bit and lets the seq_off_mode input choose)
// - after fault shutdown apply retry field
// - retry zero: stay off until cleared
// - nonzero retry: restart up to global limit
// - off command, bias loss, other fault stop retries (the code ignores another fault that comes during the sequenced-off wait)
// - deglitch count samples ignore new fault
// - deglitch zero turns off immediately
// - deglitch one to seven waits that many samples
// - turn-off delay limited and rounded
module ovf_responder (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ov_policy_wr,
  input wire logic uv_policy_wr,
  input wire logic [7:0] policy_wdata,
  output logic [7:0] ov_policy_rd,
  output logic [7:0] uv_policy_rd,
  input wire logic ov_detect,
  input wire logic uv_detect,
  input wire logic current_mode,
  input wire logic seq_off_mode,
  input wire logic [2:0] retry_limit,
  input wire logic [20:0] toff_delay_10us,
  input wire logic control_pin,
  input wire logic operation_on,
  input wire logic bias_ok,
  input wire logic ext_fault_off,
  input wire logic status_clear,
  output logic chan_enable,
  output logic status_vout_ov,
  output logic status_vout_uv,
  output logic status_word_vout,
  output logic status_byte_vout_ov,
  output logic alert_out_n,
  output logic alert_oe_n
);

  typedef struct packed {
    ovf_pkg::ovf_state_e st;
    logic [7:0] ov_pol;
    logic [7:0] uv_pol;
    logic [11:0] tick_cnt;
    logic [11:0] pre_cnt;
    logic [20:0] toff_cnt;
    logic [2:0] attempts;
    logic retry_block;
    logic cause_ov;
    logic st_ov;
    logic st_uv;
    logic [2:0] sync;
    logic ctl;
    logic enable;
  } ovf_core_s;

  ovf_core_s q;
  ovf_core_s next_q;

  logic sample_tick;
  logic ov_conf;
  logic uv_conf;
  logic ov_hit;
  logic uv_hit;
  logic ov_fire;
  logic uv_fire;
  logic cmd_on;
  logic [20:0] toff_steps;
  logic [2:0] cause_retry;

  // A confirmed fault acts unless its action field says keep running.
  function automatic logic fires(input logic hit, input logic [7:0] pol);
    fires = hit && (pol[ovf_pkg::ACTION_LSB +: 2] != ovf_pkg::ACT_CONTINUE);
  endfunction

  // Clamp the turn-off delay and round long delays to the coarse step.
  function automatic logic [20:0] toff_limit(input logic [20:0] req);
    logic [20:0] v;
    v = (req > ovf_pkg::TOFF_MAX_STEPS) ? ovf_pkg::TOFF_MAX_STEPS : req;
    if (v >= ovf_pkg::TOFF_COARSE_FROM) begin
      v = 21'((v + ovf_pkg::TOFF_COARSE_HALF) / ovf_pkg::TOFF_COARSE_STEP * ovf_pkg::TOFF_COARSE_STEP);
    end
    if (v > ovf_pkg::TOFF_MAX_STEPS) begin
      v = ovf_pkg::TOFF_MAX_STEPS;
    end
    toff_limit = v;
  endfunction

  // Independent deglitching for each fault type.
  ovf_deglitch u_ov_dg (
    .sys_clk(sys_clk),
    .reset(reset),
    .sample_tick(sample_tick),
    .fault_raw(ov_detect),
    .glitch_count(q.ov_pol[ovf_pkg::DEGLITCH_LSB +: 3]),
    .confirmed(ov_conf)
  );

  ovf_deglitch u_uv_dg (
    .sys_clk(sys_clk),
    .reset(reset),
    .sample_tick(sample_tick),
    .fault_raw(uv_detect),
    .glitch_count(q.uv_pol[ovf_pkg::DEGLITCH_LSB +: 3]),
    .confirmed(uv_conf)
  );

  // Qualified fault terms and the combined on command.
  assign sample_tick = (q.tick_cnt == ovf_pkg::SAMPLE_CYCLES - 12'h001);
  assign ov_hit = ov_conf && !current_mode;
  assign uv_hit = uv_conf && !current_mode;
  assign ov_fire = fires(ov_hit, q.ov_pol);
  assign uv_fire = fires(uv_hit, q.uv_pol);
  assign cmd_on = q.ctl && operation_on && bias_ok;
  assign toff_steps = toff_limit(toff_delay_10us);
  assign cause_retry = q.cause_ov ? q.ov_pol[ovf_pkg::RETRY_LSB +: 3] : q.uv_pol[ovf_pkg::RETRY_LSB +: 3];

  // Next-state logic for the whole channel.
  always_comb begin
    next_q = q;
    // The control pin is asynchronous; only the second and third stages are compared.
    next_q.sync = {q.sync[1:0], control_pin};
    if (q.sync[2] == q.sync[1]) begin
      next_q.ctl = q.sync[1];
    end
    next_q.tick_cnt = sample_tick ? 12'h000 : q.tick_cnt + 12'h001;
    if (ov_policy_wr) begin
      next_q.ov_pol = policy_wdata;
    end
    if (uv_policy_wr) begin
      next_q.uv_pol = policy_wdata;
    end
    // A fault in the clearing cycle still lands, so no event is lost.
    if (status_clear) begin
      next_q.st_ov = 1'b0;
      next_q.st_uv = 1'b0;
    end
    if (ov_hit) begin
      next_q.st_ov = 1'b1;
    end
    if (uv_hit) begin
      next_q.st_uv = 1'b1;
    end
    case (q.st)
      ovf_pkg::ST_OFF: begin
        if (cmd_on) begin
          next_q.st = ovf_pkg::ST_ON;
          next_q.attempts = 3'h0;
          next_q.retry_block = 1'b0;
        end
      end
      ovf_pkg::ST_ON: begin
        if (!cmd_on) begin
          next_q.st = ovf_pkg::ST_OFF;
        end else if (ext_fault_off) begin
          next_q.st = ovf_pkg::ST_FAULTED;
          next_q.retry_block = 1'b1;
        end else if (ov_fire || uv_fire) begin
          // Overvoltage takes priority when both fire together.
          next_q.cause_ov = ov_fire;
          if (seq_off_mode && toff_steps != 21'h0) begin
            next_q.st = ovf_pkg::ST_SEQ_OFF;
            next_q.toff_cnt = toff_steps;
            next_q.pre_cnt = 12'h000;
          end else begin
            next_q.st = ovf_pkg::ST_FAULTED;
          end
        end
      end
      ovf_pkg::ST_SEQ_OFF: begin
        if (!cmd_on) begin
          next_q.st = ovf_pkg::ST_OFF;
        end else if (q.pre_cnt == ovf_pkg::TOFF_STEP_CYCLES - 12'h001) begin
          next_q.pre_cnt = 12'h000;
          next_q.toff_cnt = q.toff_cnt - 21'h1;
          if (q.toff_cnt == 21'h1) begin
            next_q.st = ovf_pkg::ST_FAULTED;
          end
        end else begin
          next_q.pre_cnt = q.pre_cnt + 12'h001;
        end
      end
      ovf_pkg::ST_FAULTED: begin
        // Restart once per sample period while attempts remain.
        if (!cmd_on) begin
          next_q.st = ovf_pkg::ST_OFF;
        end else if (ext_fault_off) begin
          next_q.retry_block = 1'b1;
        end else if (cause_retry != ovf_pkg::RETRY_NONE && !q.retry_block &&
                     q.attempts < retry_limit && sample_tick) begin
          next_q.st = ovf_pkg::ST_ON;
          next_q.attempts = q.attempts + 3'h1;
        end
      end
      default: begin
        next_q.st = ovf_pkg::ST_OFF;
      end
    endcase
    next_q.enable = (next_q.st == ovf_pkg::ST_ON) || (next_q.st == ovf_pkg::ST_SEQ_OFF);
  end

  // State register.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q <= '{st: ovf_pkg::ST_OFF, ov_pol: ovf_pkg::POLICY_RESET, uv_pol: ovf_pkg::POLICY_RESET, default: '0};
    end else begin
      q <= next_q;
    end
  end

  // Outputs; the alert pin is open drain and only ever pulled low.
  assign ov_policy_rd = q.ov_pol;
  assign uv_policy_rd = q.uv_pol;
  assign chan_enable = q.enable;
  assign status_vout_ov = q.st_ov;
  assign status_vout_uv = q.st_uv;
  assign status_word_vout = q.st_ov || q.st_uv;
  assign status_byte_vout_ov = q.st_ov;
  assign alert_out_n = !(q.st_ov || q.st_uv);
  assign alert_oe_n = !(q.st_ov || q.st_uv);

  property p_status;
    @(posedge sys_clk) disable iff (reset)
      ov_hit |=> (status_vout_ov && status_word_vout && status_byte_vout_ov);
  endproperty
  a_status: assert property (p_status) else $error("fault did not set status bits");

  property p_alert;
    @(posedge sys_clk) disable iff (reset)
      (uv_hit && !status_clear) |=> (!alert_out_n && !alert_oe_n);
  endproperty
  a_alert: assert property (p_alert) else $error("alert not asserted after fault");

  property p_current;
    @(posedge sys_clk) disable iff (reset)
      (current_mode && !status_vout_ov && !status_vout_uv) |=> (!status_vout_ov && !status_vout_uv);
  endproperty
  a_current: assert property (p_current) else $error("current channel reacted to voltage fault");

  property p_continue;
    @(posedge sys_clk) disable iff (reset)
      (q.st == ovf_pkg::ST_ON && cmd_on && !ext_fault_off && q.ov_pol[7:6] == 2'h0 && q.uv_pol[7:6] == 2'h0)
        |=> chan_enable;
  endproperty
  a_continue: assert property (p_continue) else $error("channel stopped with continue action");

  sequence s_fault_fires;
    q.st == ovf_pkg::ST_ON && cmd_on && !ext_fault_off && ov_hit && q.ov_pol[7:6] != 2'h0;
  endsequence

  property p_immediate;
    @(posedge sys_clk) disable iff (reset)
      (s_fault_fires and (!seq_off_mode)) |=> (!chan_enable && q.st == ovf_pkg::ST_FAULTED);
  endproperty
  a_immediate: assert property (p_immediate) else $error("immediate shutdown missed");

  property p_sequenced;
    @(posedge sys_clk) disable iff (reset)
      (s_fault_fires and (seq_off_mode && toff_steps != 21'h0)) |=> (chan_enable && q.st == ovf_pkg::ST_SEQ_OFF);
  endproperty
  a_sequenced: assert property (p_sequenced) else $error("sequenced shutdown did not wait");

  property p_no_retry;
    @(posedge sys_clk) disable iff (reset)
      (q.st == ovf_pkg::ST_FAULTED && cmd_on && cause_retry == 3'h0) |=> (q.st == ovf_pkg::ST_FAULTED);
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("restart with zero retry field");

  property p_retry_bound;
    @(posedge sys_clk) disable iff (reset)
      (q.st == ovf_pkg::ST_FAULTED && $past(q.st) == ovf_pkg::ST_ON && $stable(retry_limit))
        |-> (q.attempts <= retry_limit);
  endproperty
  a_retry_bound: assert property (p_retry_bound) else $error("restarts exceeded global limit");

  property p_cmd_off;
    @(posedge sys_clk) disable iff (reset)
      (!cmd_on && q.st != ovf_pkg::ST_OFF) |=> (q.st == ovf_pkg::ST_OFF && !chan_enable) [*2];
  endproperty
  a_cmd_off: assert property (p_cmd_off) else $error("off command did not stop the channel");

  property p_attempt_reset;
    @(posedge sys_clk) disable iff (reset)
      (q.st == ovf_pkg::ST_OFF && cmd_on) |=> (q.attempts == 3'h0 && !q.retry_block);
  endproperty
  a_attempt_reset: assert property (p_attempt_reset) else $error("on command kept old attempts");

  property p_toff_limit;
    @(posedge sys_clk) disable iff (reset)
      toff_steps <= ovf_pkg::TOFF_MAX_STEPS;
  endproperty
  a_toff_limit: assert property (p_toff_limit) else $error("turn-off delay above limit");

endmodule

/* File: sim/ovf_supply_model.sv */
// Model of the supervised supply and of the host's alert pull-up.
`timescale 1ns/100ps
module ovf_supply_model (
  input wire logic chan_enable,
  input wire logic inject_ov,
  input wire logic inject_uv,
  input wire logic alert_oe_n,
  output logic ov_detect,
  output logic uv_detect,
  output logic alert_wire
);
  // A disabled supply is masked, so a restart into a lasting fault trips again at once.
  assign ov_detect = inject_ov & chan_enable;
  assign uv_detect = inject_uv & chan_enable;
  // Open drain line: low while driven, otherwise the pull-up wins.
  assign alert_wire = alert_oe_n ? 1'b1 : 1'b0;
endmodule

/* File: sim/ovf_responder_bench.sv */
// Self-checking bench for the output voltage fault responder.
`timescale 1ns/100ps
module ovf_responder_bench;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic ov_policy_wr = 1'b0, uv_policy_wr = 1'b0, current_mode = 1'b0, seq_off_mode = 1'b0;
  logic control_pin = 1'b1, operation_on = 1'b1, bias_ok = 1'b1, ext_fault_off = 1'b0;
  logic status_clear = 1'b0, inject_ov = 1'b0, inject_uv = 1'b0;
  logic [7:0] policy_wdata = 8'h00;
  logic [2:0] retry_limit = 3'h2;
  logic [20:0] toff_delay_10us = 21'h00_0000;
  logic [7:0] ov_policy_rd, uv_policy_rd;
  logic ov_detect, uv_detect, chan_enable, status_vout_ov, status_vout_uv;
  logic status_word_vout, status_byte_vout_ov, alert_out_n, alert_oe_n, alert_wire;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  int rises = 0;

  // The clock is 250 MHz.
  always #2 sys_clk = ~sys_clk;

  ovf_responder DUT (.sys_clk(sys_clk), .reset(reset), .ov_policy_wr(ov_policy_wr),
    .uv_policy_wr(uv_policy_wr), .policy_wdata(policy_wdata), .ov_policy_rd(ov_policy_rd),
    .uv_policy_rd(uv_policy_rd), .ov_detect(ov_detect), .uv_detect(uv_detect),
    .current_mode(current_mode), .seq_off_mode(seq_off_mode), .retry_limit(retry_limit),
    .toff_delay_10us(toff_delay_10us), .control_pin(control_pin), .operation_on(operation_on),
    .bias_ok(bias_ok), .ext_fault_off(ext_fault_off), .status_clear(status_clear),
    .chan_enable(chan_enable), .status_vout_ov(status_vout_ov), .status_vout_uv(status_vout_uv),
    .status_word_vout(status_word_vout), .status_byte_vout_ov(status_byte_vout_ov),
    .alert_out_n(alert_out_n), .alert_oe_n(alert_oe_n));

  ovf_supply_model supply (.chan_enable(chan_enable), .inject_ov(inject_ov), .inject_uv(inject_uv),
    .alert_oe_n(alert_oe_n), .ov_detect(ov_detect), .uv_detect(uv_detect), .alert_wire(alert_wire));

  // Restarts are counted as rising edges of the enable.
  always @(posedge chan_enable) rises++;

  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // The run is about 40350 cycles, so this ceiling only catches a hang.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 90000) begin
      error_cnt++;
      close_out();
    end
  end

  // Inputs always move 1 ns after the rising edge, never on it.
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle write strobe; the readback is registered one edge later.
  task automatic wr_pol(input logic ov, input logic [7:0] d);
    ov_policy_wr = ov;
    uv_policy_wr = !ov;
    policy_wdata = d;
    tick(1);
    ov_policy_wr = 1'b0;
    uv_policy_wr = 1'b0;
  endtask

  // Bounded wait for the enable to reach a level, then a compare.
  task automatic wait_en(input logic val, input int max);
    for (int i = 0; i < max && chan_enable !== val; i++) tick(1);
    chk("chan_enable", {7'h0, val}, {7'h0, chan_enable});
  endtask

  // A fresh on command after a short off period.
  task automatic power_cycle();
    operation_on = 1'b0;
    tick(3);
    operation_on = 1'b1;
    wait_en(1'b1, 10);
  endtask

  // Main sequence.
  initial begin
    tick(8);
    reset = 1'b0;
    chk("ov_policy_rd", 8'h00, ov_policy_rd);
    chk("chan_enable", 8'h00, {7'h0, chan_enable});
    chk("alert_out_n", 8'h01, {7'h0, alert_out_n});
    wr_pol(1'b1, 8'h88);
    wr_pol(1'b0, 8'h42);
    chk("ov_policy_rd", 8'h88, ov_policy_rd);
    chk("uv_policy_rd", 8'h42, uv_policy_rd);
    wait_en(1'b1, 20);
    // A continue policy only flags the fault.
    wr_pol(1'b1, 8'h00);
    inject_ov = 1'b1;
    tick(5);
    inject_ov = 1'b0;
    tick(2);
    chk("chan_enable", 8'h01, {7'h0, chan_enable});
    chk("status_vout_ov", 8'h01, {7'h0, status_vout_ov});
    chk("status_vout_uv", 8'h00, {7'h0, status_vout_uv});
    chk("status_word", 8'h03, {6'h0, status_word_vout, status_byte_vout_ov});
    chk("alert", 8'h00, {6'h0, alert_out_n, alert_wire});
    status_clear = 1'b1;
    tick(1);
    status_clear = 1'b0;
    tick(1);
    chk("alert_out_n", 8'h01, {7'h0, alert_out_n});
    // A current measuring channel ignores even a shutdown policy.
    current_mode = 1'b1;
    wr_pol(1'b0, 8'h80);
    inject_uv = 1'b1;
    tick(10);
    chk("chan_enable", 8'h01, {7'h0, chan_enable});
    chk("status_vout_uv", 8'h00, {7'h0, status_vout_uv});
    // The confirmation lags the comparator by an edge, so it must fall away before the channel listens again.
    inject_uv = 1'b0;
    tick(2);
    current_mode = 1'b0;
    // Immediate shutdown with no retry stays off until a new on command.
    wr_pol(1'b1, 8'h80);
    inject_ov = 1'b1;
    tick(4);
    chk("chan_enable", 8'h00, {7'h0, chan_enable});
    inject_ov = 1'b0;
    tick(3100);
    chk("chan_enable", 8'h00, {7'h0, chan_enable});
    power_cycle();
    // A gap restarts the deglitch count; a lasting fault trips after two samples.
    wr_pol(1'b0, 8'h42);
    inject_uv = 1'b1;
    tick(3000);
    inject_uv = 1'b0;
    tick(2);
    inject_uv = 1'b1;
    // Without the restart the second sample would already have tripped before this check.
    tick(3100);
    chk("chan_enable", 8'h01, {7'h0, chan_enable});
    wait_en(1'b0, 3100);
    inject_uv = 1'b0;
    power_cycle();
    // A lasting fault is retried exactly the global limit of times.
    wr_pol(1'b1, 8'h88);
    rises = 0;
    inject_ov = 1'b1;
    tick(13000);
    chk("restarts", 8'h02, 8'(rises));
    inject_ov = 1'b0;
    power_cycle();
    rises = 0;
    inject_ov = 1'b1;
    tick(7000);
    chk("restarts", 8'h02, 8'(rises));
    inject_ov = 1'b0;
    power_cycle();
    // Another fault blocks restarts until the next on command.
    ext_fault_off = 1'b1;
    tick(2);
    ext_fault_off = 1'b0;
    tick(3100);
    chk("chan_enable", 8'h00, {7'h0, chan_enable});
    power_cycle();
    // Sequenced off waits 2 steps of 2500 cycles.
    seq_off_mode = 1'b1;
    toff_delay_10us = 21'h00_0002;
    wr_pol(1'b1, 8'h80);
    inject_ov = 1'b1;
    tick(4900);
    chk("chan_enable", 8'h01, {7'h0, chan_enable});
    wait_en(1'b0, 300);
    inject_ov = 1'b0;
    seq_off_mode = 1'b0;
    power_cycle();
    // The control pin passes three stages, so its off command only lands on the fifth edge.
    control_pin = 1'b0;
    tick(3);
    chk("chan_enable", 8'h01, {7'h0, chan_enable});
    tick(2);
    chk("chan_enable", 8'h00, {7'h0, chan_enable});
    control_pin = 1'b1;
    wait_en(1'b1, 10);
    // Long turn-off delays go through the clamp and the coarse rounding.
    toff_delay_10us = 21'h1f_ffff;
    tick(2);
    toff_delay_10us = 21'h01_0005;
    tick(2);
    bias_ok = 1'b0;
    tick(3);
    chk("chan_enable", 8'h00, {7'h0, chan_enable});
    close_out();
  end
endmodule
